// ===== hw/opv_pkg.sv
// package: modes, widths and pin groups of the otp programming port
package opv_pkg;
  localparam int unsigned ADDR_W      = 14;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned STEP_PULSES = 4;
  localparam logic [13:0] ADDR_RST    = 14'h0000;
  localparam logic [1:0]  PCNT_RST    = 2'h0;
  localparam logic [7:0]  DATA_RST    = 8'h00;
  // mode pins, bit 0 = first select pin
  localparam logic [3:0] MODE_CLR     = 4'h5;
  localparam logic [3:0] MODE_WRITE   = 4'he;
  localparam logic [3:0] MODE_VERIFY  = 4'hc;
  localparam logic [3:0] MODE_INH_MSK = 4'hd;
  localparam logic [3:0] MODE_INH_VAL = 4'hd;

  typedef enum logic [2:0] {
    OPV_IDLE    = 3'b000,
    OPV_CLEAR   = 3'b001,
    OPV_WRITE   = 3'b010,
    OPV_VERIFY  = 3'b011,
    OPV_INHIBIT = 3'b100
  } opv_mode_t;

  typedef struct packed {
    logic [3:0] prog_data_high_nibble;
    logic [3:0] prog_data_low_nibble;
  } opv_data_t;

  typedef struct packed {
    opv_data_t dout;
    logic [7:0] oe_n;
  } opv_pad_t;
endpackage : opv_pkg

// ===== hw/opv_mode_dec.sv
// mode-select decoder of the otp programming port
`timescale 1ns/1ps
`default_nettype none
module opv_mode_dec (
  // mode pins
  input  wire logic [3:0]         prog_mode_select,
  // decoded mode
  output var  opv_pkg::opv_mode_t mode
);
  always_comb begin
    if (prog_mode_select == opv_pkg::MODE_CLR) begin
      mode = opv_pkg::OPV_CLEAR; // [R3]
    end else if (prog_mode_select == opv_pkg::MODE_WRITE) begin
      mode = opv_pkg::OPV_WRITE; // [R3]
    end else if (prog_mode_select == opv_pkg::MODE_VERIFY) begin
      mode = opv_pkg::OPV_VERIFY; // [R3]
    end else if ((prog_mode_select & opv_pkg::MODE_INH_MSK)
                 == opv_pkg::MODE_INH_VAL) begin
      mode = opv_pkg::OPV_INHIBIT; // [R3]
    end else begin
      mode = opv_pkg::OPV_IDLE;
    end
  end
endmodule : opv_mode_dec
`default_nettype wire

// ===== hw/opv_prog_port.sv
// otp program memory write/verify port with internal address counter
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] address comes only from stepping clock pulses
// [R2] programmer drives inverted step clock on pin two
// [R3] mode pins select clear, write, verify, inhibit
// [R4] byte port: sampled on write, driven on verify
// [R5] programmer settles, then clears before high voltage
// [R6] programmer writes 1 ms then verifies, repeating
// [R7] programmer adds extra write of attempts times 1 ms
// [R8] four step pulses advance address by one
// [R9] verify presents one byte per four pulses
// [R10] programmer loops to end, then clears
module opv_prog_port #(
  parameter int unsigned ADDR_W = opv_pkg::ADDR_W,
  parameter int unsigned DEPTH  = 16384
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // programmer pins
  input  wire logic             addr_step_clock,
  input  wire logic             addr_step_clock_inv,
  input  wire logic [3:0]       prog_mode_select,
  input  wire opv_pkg::opv_data_t prog_data_in,
  // data pad drive
  output var  opv_pkg::opv_data_t prog_data_out,
  output var  logic [7:0]       prog_data_oe_n,
  // status
  output var  logic [ADDR_W-1:0] prog_addr,
  output var  logic             prog_busy_write
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0]   addr_q;
    logic [1:0]          pcnt_q;
    logic                step_q;
    opv_pkg::opv_data_t  dout_q;
    logic [7:0]          oe_n_q;
    logic                wr_q;
  } opv_state_t;

  opv_state_t         s_q;
  opv_state_t         s_d;
  opv_pkg::opv_mode_t mode;
  logic [7:0]         mem_q [DEPTH];
  logic               rise;
  logic [7:0]         rd_byte;
  logic               wr_en;

  // ****************************************
  // helpers
  // ****************************************
  // clear and inhibit both freeze the pulse counter; clear also zeroes it
  function automatic logic counts_pulse(opv_pkg::opv_mode_t m);
    return (m != opv_pkg::OPV_CLEAR) && (m != opv_pkg::OPV_INHIBIT);
  endfunction : counts_pulse


  opv_mode_dec u_dec (
    .prog_mode_select (prog_mode_select),
    .mode             (mode)
  );

  // ****************************************
  // address stepping
  // ****************************************
  // the inverted pin only matters to the oscillator pad; logic uses one
  // edge source so a skewed complement cannot double count
  assign rise    = addr_step_clock & ~s_q.step_q; // [R1]
  assign rd_byte = mem_q[s_q.addr_q];
  // no write while the verify driver still holds the pad
  assign wr_en   = (mode == opv_pkg::OPV_WRITE) && (s_q.oe_n_q == 8'hff);

  always_comb begin
    s_d        = s_q;
    s_d.step_q = addr_step_clock;
    s_d.wr_q   = (mode == opv_pkg::OPV_WRITE);
    if (mode == opv_pkg::OPV_CLEAR) begin
      s_d.addr_q = ADDR_W'(opv_pkg::ADDR_RST); // [R3]
      s_d.pcnt_q = opv_pkg::PCNT_RST;
    end else if (rise && counts_pulse(mode)) begin
      s_d.pcnt_q = s_q.pcnt_q + 2'h1; // [R8]
      if (s_q.pcnt_q == 2'(opv_pkg::STEP_PULSES - 1)) begin
        s_d.addr_q = s_q.addr_q + ADDR_W'(1); // [R8]
      end
    end
    if (mode == opv_pkg::OPV_VERIFY) begin
      s_d.dout_q = rd_byte; // [R9]
      s_d.oe_n_q = 8'h00; // [R4]
    end else begin
      s_d.dout_q = opv_pkg::DATA_RST;
      s_d.oe_n_q = 8'hff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{addr_q: '0, pcnt_q: 2'h0, step_q: 1'b0,
               dout_q: 8'h00, oe_n_q: 8'hff, wr_q: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // otp cell: once programmed a bit only gains ones, never clears;
  // a write straight after verify waits one cycle for the pad to float,
  // else the device would burn its own read data back into the cell.
  // limitation: reset models a blank part, a real array keeps its data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= opv_pkg::DATA_RST;
      end
    end else if (wr_en) begin
      mem_q[s_q.addr_q] <= mem_q[s_q.addr_q] | prog_data_in; // [R4]
    end
  end

  assign prog_data_out   = s_q.dout_q;
  assign prog_data_oe_n  = s_q.oe_n_q;
  assign prog_addr       = s_q.addr_q;
  assign prog_busy_write = s_q.wr_q;

  // ****************************************
  // checks
  // ****************************************

  // clear mode wins over any step pulse
  chk_clear_zero: assert property ( // [R3]
    @(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_CLEAR |=> s_q.addr_q == '0)
    else $error("address not cleared");

  // no pulse, no movement
  chk_addr_hold: assert property ( // [R1]
    @(posedge clk_sys) disable iff (!rst_n)
    !rise && mode != opv_pkg::OPV_CLEAR |=> $stable(s_q.addr_q))
    else $error("address moved without step pulse");

  // fourth counted pulse carries into the address
  chk_four_step: assert property ( // [R8]
    @(posedge clk_sys) disable iff (!rst_n)
    rise && s_q.pcnt_q == 2'h3 && mode != opv_pkg::OPV_CLEAR
    && mode != opv_pkg::OPV_INHIBIT
    |=> s_q.addr_q == $past(s_q.addr_q) + ADDR_W'(1))
    else $error("address not advanced on fourth pulse");

  // first three pulses only move the pulse counter
  chk_partial_step: assert property ( // [R8]
    @(posedge clk_sys) disable iff (!rst_n)
    rise && s_q.pcnt_q != 2'h3 |=> $stable(s_q.addr_q)
    || $past(mode) == opv_pkg::OPV_CLEAR)
    else $error("address advanced early");

  // pulse counter steps by one per counted pulse
  chk_pcnt_step: assert property ( // [R8]
    @(posedge clk_sys) disable iff (!rst_n)
    rise && counts_pulse(mode)
    |=> s_q.pcnt_q == $past(s_q.pcnt_q) + 2'h1)
    else $error("pulse not counted");

  // clear also drops a half-finished group of pulses
  chk_pcnt_clear: assert property ( // [R3]
    @(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_CLEAR |=> s_q.pcnt_q == 2'h0)
    else $error("pulse count not cleared");

  // edge detector follows the pin one cycle late
  chk_step_track: assert property ( // [R1]
    @(posedge clk_sys) disable iff (!rst_n)
    addr_step_clock |=> s_q.step_q)
    else $error("step pin not tracked");

  // verify turns the pad around one cycle after the mode
  chk_verify_drive: assert property ( // [R4]
    @(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_VERIFY |=> prog_data_oe_n == 8'h00)
    else $error("port not driven in verify");

  // write samples the pad, so the driver must be off
  chk_write_float: assert property ( // [R4]
    @(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_WRITE |=> prog_data_oe_n == 8'hff)
    else $error("port driven during write");

  // every mode but verify leaves the pad floating
  chk_idle_float: assert property ( // [R4]
    @(posedge clk_sys) disable iff (!rst_n)
    mode != opv_pkg::OPV_VERIFY |=> prog_data_oe_n == 8'hff)
    else $error("port driven outside verify");

  // floating pad carries the quiet value, not stale read data
  chk_dout_quiet: assert property ( // [R4]
    @(posedge clk_sys) disable iff (!rst_n)
    mode != opv_pkg::OPV_VERIFY |=> prog_data_out == opv_pkg::DATA_RST)
    else $error("stale data left on port");

  // read data follows the cell at the current address
  chk_verify_data: assert property ( // [R9]
    @(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_VERIFY ##1 mode == opv_pkg::OPV_VERIFY
    |-> prog_data_out == $past(rd_byte))
    else $error("verify data mismatch");

  // inhibit ignores pulses
  chk_inhibit_hold: assert property ( // [R3]
    @(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_INHIBIT |=> $stable(s_q.pcnt_q))
    else $error("pulse counted in inhibit");

  // inhibit also keeps the address where it is
  chk_inhibit_addr: assert property ( // [R3]
    @(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_INHIBIT |=> $stable(s_q.addr_q))
    else $error("address moved in inhibit");

  // write flag follows the decoded mode
  chk_busy_write: assert property ( // [R3]
    @(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_WRITE |=> prog_busy_write)
    else $error("write flag missing");

  // and drops one cycle after the mode leaves write
  chk_busy_clear: assert property ( // [R3]
    @(posedge clk_sys) disable iff (!rst_n)
    mode != opv_pkg::OPV_WRITE |=> !prog_busy_write)
    else $error("write flag stuck");

  // ****************************************
  // coverage of the main scenarios
  // ****************************************
  cov_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_WRITE ##1 mode == opv_pkg::OPV_VERIFY);

  cov_step: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rise && s_q.pcnt_q == 2'h3);

  cov_clear: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_CLEAR ##1 mode == opv_pkg::OPV_VERIFY);

  cov_read_step: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_VERIFY && rise && s_q.pcnt_q == 2'h3);

  cov_rewrite: cover property (@(posedge clk_sys) disable iff (!rst_n)
    mode == opv_pkg::OPV_VERIFY ##1 mode == opv_pkg::OPV_WRITE);

endmodule : opv_prog_port
`default_nettype wire

// ===== verification/opv_step_model.sv
// programmer model: complementary step clock pair
`timescale 1ns/1ps
`default_nettype none
module opv_step_model (
  // clock and request
  input  wire logic       clk_sys,
  input  wire logic [2:0] np,
  // step clock pins
  output var  logic       stp,
  output var  logic       stp_n
);
  int n = 0;
  // low between bursts; two cycles high, two low per pulse
  always @(posedge clk_sys) begin
    if (n > 0) n <= n - 1;
    else n <= 4 * np;
  end
  always_comb stp = (n > 0) && n[1];
  always_comb stp_n = ~stp;
endmodule : opv_step_model
`default_nettype wire

// ===== verification/tb_opv_prog_port.sv
// testbench for the otp programming port
`timescale 1ns/1ps
`default_nettype none
module tb_opv_prog_port;
  logic               clk_sys = 0;
  logic               rst_n   = 0;
  logic [3:0]         md      = 4'h0;
  logic [7:0]         drv     = 8'h00;
  logic [2:0]         np      = 3'h0;
  logic               stp, stp_n, busy;
  logic [7:0]         oe_n;
  logic [3:0]         addr;
  opv_pkg::opv_data_t dout;
  wire  [7:0]         pad = (oe_n & drv) | (~oe_n & dout);
  int                 n_errors = 0;
  int                 checks_done = 0;
  initial forever #5 clk_sys = ~clk_sys;
  opv_step_model pm (.clk_sys(clk_sys), .np(np), .stp(stp), .stp_n(stp_n));
  // small depth keeps the address counter short
  opv_prog_port #(.ADDR_W(4), .DEPTH(16)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .addr_step_clock(stp),
    .addr_step_clock_inv(stp_n), .prog_mode_select(md),
    .prog_data_in(opv_pkg::opv_data_t'(pad)), .prog_data_out(dout),
    .prog_data_oe_n(oe_n), .prog_addr(addr), .prog_busy_write(busy));
  task automatic chk(string s, logic [13:0] e, logic [13:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic set_mode(logic [3:0] m, logic [7:0] d);
    @(posedge clk_sys) md <= m;
    drv <= d;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : set_mode
  task automatic step(logic [2:0] k);
    @(posedge clk_sys) np <= k;
    @(posedge clk_sys) np <= 3'h0;
    repeat (4 * k + 3) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic t_write;
    set_mode(opv_pkg::MODE_CLR, 8'h00);
    chk("addr", 14'h0, addr);
    set_mode(opv_pkg::MODE_WRITE, 8'ha5);
    chk("busy", 14'h1, busy);
    chk("oe_n", 14'hff, oe_n);
    set_mode(opv_pkg::MODE_VERIFY, 8'h00);
    chk("busy", 14'h0, busy);
    chk("oe_n", 14'h0, oe_n);
    chk("data", 14'ha5, dout);
    set_mode(opv_pkg::MODE_WRITE, 8'h5a);
    set_mode(opv_pkg::MODE_VERIFY, 8'h00);
    chk("data", 14'hff, dout);
    $display("done write");
  endtask : t_write
  task automatic t_step;
    step(3'h3);
    chk("addr", 14'h0, addr);
    step(3'h1);
    chk("addr", 14'h1, addr);
    set_mode(opv_pkg::MODE_INH_VAL, 8'h00);
    step(3'h4);
    chk("addr", 14'h1, addr);
    set_mode(opv_pkg::MODE_WRITE, 8'h3c);
    set_mode(4'h0, 8'h00);
    chk("oe_n", 14'hff, oe_n);
    $display("done step");
  endtask : t_step
  task automatic t_read;
    set_mode(opv_pkg::MODE_CLR, 8'h00);
    chk("addr", 14'h0, addr);
    set_mode(opv_pkg::MODE_VERIFY, 8'h00);
    chk("data", 14'hff, dout);
    step(3'h4);
    chk("addr", 14'h1, addr);
    chk("data", 14'h3c, dout);
    $display("done read");
  endtask : t_read
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    chk("addr", 14'h0, addr);
    chk("oe_n", 14'hff, oe_n);
    $display("done reset");
    t_write();
    t_step();
    t_read();
    report_and_stop();
  end
  // run needs about a hundred cycles
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
endmodule : tb_opv_prog_port
`default_nettype wire
